// [rtl/emb_pkg.sv]
// Package for the external memory bus interface: types, states and timing counts.
package emb_pkg;

    // ************************************************************
    // Address map and widths
    // ************************************************************
    localparam int          ADDR_W         = 16;        // 64K program and data spaces.
    localparam int          DATA_W         = 8;         // Byte-wide bus.
    localparam logic [15:0] ONCHIP_LIMIT   = 16'h4000;  // First address beyond the 16K store.

    // ************************************************************
    // Timing counts
    // ************************************************************
    localparam int          CLK_PER_MC     = 12;        // Clocks in one machine cycle.
    localparam int          RST_MC         = 2;         // Machine cycles reset must be held.
    localparam int          RST_CLKS       = CLK_PER_MC * RST_MC;
    localparam int          PHASE_CLKS     = 2;         // Clocks in each bus phase.
    localparam logic [1:0]  PHASE_LAST     = 2'(PHASE_CLKS - 1);
    localparam logic [4:0]  RST_LAST       = 5'(RST_CLKS - 1);

    // ************************************************************
    // Access kinds
    // ************************************************************
    typedef enum logic [1:0] {
        EMB_FETCH = 2'h0,  // Instruction fetch.
        EMB_CTAB  = 2'h1,  // Code table read.
        EMB_DRD   = 2'h2,  // Data memory read.
        EMB_DWR   = 2'h3   // Data memory write.
    } emb_kind_e;

    // Request from the core.
    typedef struct packed {
        emb_kind_e           kind;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } emb_req_s;

    // Bus sequencer states, one-hot.
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,  // Waiting for a request.
        ST_ADDR = 5'h02,  // Address out, latch strobe high.
        ST_HOLD = 5'h04,  // Latch strobe falls, address held.
        ST_DATA = 5'h08,  // Read or write strobe active.
        ST_DONE = 5'h10   // Strobes released, answer given.
    } emb_state_e;

endpackage : emb_pkg

// [rtl/emb_sync2.sv]
// Two-flip-flop synchroniser for a vector of pin inputs.
`timescale 1ns/1ps
module emb_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_ce,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_async,
    input  wire logic [W-1:0] i_rst_val,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta_r;  // First stage, read only by the second.

    // ************************************************************
    // Two stages; the reset value is a constant fed by the parent.
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            meta_r <= i_rst_val;
            o_sync <= i_rst_val;
        end else if (i_ce) begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end

endmodule : emb_sync2

// [rtl/emb_bus_if.sv]
// External memory bus sequencer: fetch, code table and data memory transfers.
//
// Functional notes
// - External-fetch select low forces all fetches external.
// - Select high and on-chip code address: bus quiet.
// - Program strobe for external fetch and tables.
// - Program strobe idle for on-chip code.
// - Latch strobe pulses in each external access.
// - Low port carries address, then data.
// - High port carries upper address byte.
// - Third-port pins give write, read strobes.
// - Reset held two machine cycles ends activity.
// - Program and data spaces split by strobes.
`timescale 1ns/1ps
module emb_bus_if
    import emb_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_ce,                 // Freezes all state when low.
    input  wire logic              i_sys_rst,            // Synchronous, active high.
    input  wire logic              i_rst_pin,            // Reset pin, asynchronous.
    input  wire logic              i_external_fetch_select, // Pin, low forces external code.
    input  wire logic              i_req_valid,          // Core request strobe.
    input  wire emb_req_s          i_req,                // Core request contents.
    input  wire logic [DATA_W-1:0] i_onchip_code,        // Byte from the on-chip store.
    input  wire logic [DATA_W-1:0] i_low_port_in,        // Low address/data port level.
    output logic                   o_req_ready,          // Ready for a new request.
    output logic                   o_rsp_valid,          // One-cycle answer pulse.
    output logic [DATA_W-1:0]      o_rsp_data,           // Byte read.
    output logic                   o_onchip_rd,          // On-chip store read pulse.
    output logic                   o_core_rst,           // Device reset after pin filter.
    output logic [DATA_W-1:0]      o_low_port_out,       // Low address/data port drive.
    output logic                   o_low_port_oe_n,      // Low while the port is driven.
    output logic [DATA_W-1:0]      o_high_address_port,  // Upper address byte.
    output logic                   o_ale,                // Address-latch strobe, high pulse.
    output logic                   o_program_read_strobe_n, // Program read, active low.
    output logic                   o_wr_n,               // Data write strobe on pin 3.6.
    output logic                   o_rd_n                // Data read strobe on pin 3.7.
);

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    logic [1:0] pins_s;       // Synchronised reset pin and fetch select.
    logic [DATA_W-1:0] din_s; // Synchronised low port.

    emb_sync2 #(.W(2)) u_sync_pins (
        .i_clk     (i_clk),
        .i_ce      (i_ce),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_rst_pin, i_external_fetch_select}),
        .i_rst_val (2'h1),
        .o_sync    (pins_s)
    );

    emb_sync2 #(.W(DATA_W)) u_sync_data (
        .i_clk     (i_clk),
        .i_ce      (i_ce),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_low_port_in),
        .i_rst_val (8'h00),
        .o_sync    (din_s)
    );

    // ************************************************************
    // Reset pin filter
    // ************************************************************
    logic [4:0] rst_cnt_r;  // Clocks the reset pin has been high.
    logic       dev_rst;    // Combined reset of the sequencer.

    // A short glitch on the pin is ignored; only a high lasting two machine
    // cycles resets the device, after which the pin level alone holds it.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rst_cnt_r  <= 5'h00;
            o_core_rst <= 1'b1;
        end else if (i_ce) begin
            if (!pins_s[1]) begin
                rst_cnt_r  <= 5'h00;
                o_core_rst <= 1'b0;
            end else if (rst_cnt_r == RST_LAST) begin
                o_core_rst <= 1'b1;
            end else begin
                rst_cnt_r <= rst_cnt_r + 5'h01;
            end
        end
    end

    assign dev_rst = i_sys_rst | o_core_rst;

    // ************************************************************
    // Request decode
    // ************************************************************
    logic is_code;   // Request targets program space.
    logic go_ext;    // Request needs the external bus.

    always_comb begin
        is_code = (i_req.kind == EMB_FETCH) || (i_req.kind == EMB_CTAB);
        // Data space is always external; code is external when the select
        // pin is low or the address is beyond the on-chip store.
        go_ext  = !is_code || !pins_s[0] || (i_req.addr >= ONCHIP_LIMIT);
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    emb_state_e state_r;   // Current bus phase.
    emb_req_s   cur_r;     // Request being served.
    logic [1:0] ph_cnt_r;  // Clocks spent in the phase.
    logic       ph_end;    // Phase complete.
    logic       go_ext_r;  // Running request uses the pins.

    assign ph_end = (ph_cnt_r == PHASE_LAST);

    // State and captured request; on-chip code reads finish in one cycle
    // without touching any pin.
    always_ff @(posedge i_clk) begin
        if (dev_rst) begin
            state_r     <= ST_IDLE;
            cur_r       <= '0;
            ph_cnt_r    <= 2'h0;
            o_req_ready <= 1'b0;
            o_rsp_valid <= 1'b0;
            o_rsp_data  <= 8'h00;
            o_onchip_rd <= 1'b0;
        end else if (i_ce) begin
            o_rsp_valid <= 1'b0;
            o_onchip_rd <= 1'b0;
            ph_cnt_r    <= ph_end ? 2'h0 : ph_cnt_r + 2'h1;
            unique case (state_r)
                ST_IDLE: begin
                    o_req_ready <= 1'b1;
                    ph_cnt_r    <= 2'h0;
                    if (i_req_valid && o_req_ready) begin
                        cur_r <= i_req;
                        if (go_ext) begin
                            state_r     <= ST_ADDR;
                            o_req_ready <= 1'b0;
                        end else begin
                            o_onchip_rd <= 1'b1;
                            state_r     <= ST_DONE;
                            o_req_ready <= 1'b0;
                        end
                    end
                end
                ST_ADDR: if (ph_end) state_r <= ST_HOLD;
                ST_HOLD: if (ph_end) state_r <= ST_DATA;
                ST_DATA: if (ph_end) state_r <= ST_DONE;
                ST_DONE: begin
                    ph_cnt_r    <= 2'h0;
                    o_rsp_valid <= 1'b1;
                    // The synchronised port lags the pins by two clocks, so here
                    // it shows the byte that stood in the first strobe clock.
                    if (!go_ext_r) begin
                        o_rsp_data <= i_onchip_code;
                    end else if (cur_r.kind != EMB_DWR) begin
                        o_rsp_data <= din_s;
                    end
                    state_r     <= ST_IDLE;
                end
            endcase
        end
    end

    // Remembers whether the running request used the pins.
    always_ff @(posedge i_clk) begin
        if (dev_rst) begin
            go_ext_r <= 1'b0;
        end else if (i_ce && state_r == ST_IDLE && i_req_valid && o_req_ready) begin
            go_ext_r <= go_ext;
        end
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    logic cur_code;  // Running request is a program-space access.
    assign cur_code = (cur_r.kind == EMB_FETCH) || (cur_r.kind == EMB_CTAB);

    logic strobe_on;  // A read or write strobe is due at the next edge.
    assign strobe_on = ((state_r == ST_HOLD) && ph_end) || ((state_r == ST_DATA) && !ph_end);

    // All pins are registered; during reset every strobe is released and
    // the low port floats so nothing external is disturbed.
    always_ff @(posedge i_clk) begin
        if (dev_rst) begin
            o_low_port_out          <= 8'h00;
            o_low_port_oe_n         <= 1'b1;
            o_high_address_port     <= 8'h00;
            o_ale                   <= 1'b0;
            o_program_read_strobe_n <= 1'b1;
            o_wr_n                  <= 1'b1;
            o_rd_n                  <= 1'b1;
        end else if (i_ce) begin
            o_ale                   <= 1'b0;
            o_program_read_strobe_n <= 1'b1;
            o_wr_n                  <= 1'b1;
            o_rd_n                  <= 1'b1;
            o_low_port_oe_n         <= 1'b1;
            unique case (state_r)
                ST_ADDR: begin
                    o_ale               <= 1'b1;
                    o_low_port_out      <= cur_r.addr[7:0];
                    o_low_port_oe_n     <= 1'b0;
                    o_high_address_port <= cur_r.addr[15:8];
                end
                ST_HOLD: begin
                    // Address stays on the port while the latch strobe falls;
                    // the port is handed over one clock later.
                    if (!ph_end) begin
                        o_low_port_out  <= cur_r.addr[7:0];
                        o_low_port_oe_n <= 1'b0;
                    end
                end
                default: begin
                    // Idle, data and done leave the strobes to the block below.
                end
            endcase
            // The strobe stands for two clocks from the last hold clock, because
            // the port synchroniser needs the memory's byte two edges early.
            if (strobe_on) begin
                if (cur_code) begin
                    o_program_read_strobe_n <= 1'b0;
                end else if (cur_r.kind == EMB_DWR) begin
                    o_wr_n          <= 1'b0;
                    o_low_port_out  <= cur_r.wdata;
                    o_low_port_oe_n <= 1'b0;
                end else begin
                    o_rd_n <= 1'b0;
                end
            end
        end
    end

endmodule : emb_bus_if

// [tb/emb_bus_chk.sv]
// Concurrent checks on the pins of the external memory bus sequencer.
`timescale 1ns/1ps
module emb_bus_chk
    import emb_pkg::*;
(
    input wire logic              i_clk,
    input wire logic              i_sys_rst,
    input wire logic              i_rst_pin,
    input wire logic              i_external_fetch_select,
    input wire logic              i_req_valid,
    input wire emb_req_s          i_req,
    input wire logic              o_req_ready,
    input wire logic              o_rsp_valid,
    input wire logic              o_core_rst,
    input wire logic [DATA_W-1:0] o_low_port_out,
    input wire logic              o_low_port_oe_n,
    input wire logic [DATA_W-1:0] o_high_address_port,
    input wire logic              o_ale,
    input wire logic              o_program_read_strobe_n,
    input wire logic              o_wr_n,
    input wire logic              o_rd_n
);
    logic       take, code, ext, quiet; // Decoded request and idle-pin view.
    logic [5:0] pin_cnt_r;              // Edges the reset pin has stayed high.
    assign take  = i_req_valid && o_req_ready;
    assign code  = (i_req.kind == EMB_FETCH) || (i_req.kind == EMB_CTAB);
    assign ext   = !code || !i_external_fetch_select || (i_req.addr >= ONCHIP_LIMIT);
    assign quiet = !o_ale && o_program_read_strobe_n && o_low_port_oe_n;
    // Saturates so a long hold cannot wrap round and look short.
    always_ff @(posedge i_clk) begin
        if (!i_rst_pin) pin_cnt_r <= 6'h00;
        else if (pin_cnt_r != 6'h3F) pin_cnt_r <= pin_cnt_r + 6'h01;
    end
    a_ext_addr_phase : assert property (@(posedge i_clk)
        disable iff (i_sys_rst || o_core_rst) take && ext |-> ##2 o_ale && !o_low_port_oe_n
        && o_low_port_out == $past(i_req.addr[7:0], 2)
        && o_high_address_port == $past(i_req.addr[15:8], 2)) else $error("address phase wrong");
    a_ale_pulse : assert property (@(posedge i_clk)
        disable iff (i_sys_rst || o_core_rst) $rose(o_ale) |-> o_ale[*2] ##1 !o_ale)
        else $error("latch strobe width wrong");
    a_onchip_quiet : assert property (@(posedge i_clk)
        disable iff (i_sys_rst || o_core_rst) take && !ext |=> quiet && !o_rsp_valid
        ##1 quiet && o_rsp_valid) else $error("on-chip fetch disturbed the bus");
    a_ext_answer : assert property (@(posedge i_clk)
        disable iff (i_sys_rst || o_core_rst) take && ext |-> ##8 o_rsp_valid)
        else $error("external answer late");
    a_code_strobe : assert property (@(posedge i_clk)
        disable iff (i_sys_rst || o_core_rst) take && ext && code
        |-> ##5 !o_program_read_strobe_n && o_rd_n && o_wr_n && o_low_port_oe_n)
        else $error("program strobe wrong");
    a_data_write : assert property (@(posedge i_clk)
        disable iff (i_sys_rst || o_core_rst) take && i_req.kind == EMB_DWR
        |-> ##5 !o_wr_n && o_rd_n && o_program_read_strobe_n && !o_low_port_oe_n
        && o_low_port_out == $past(i_req.wdata, 5)) else $error("write cycle wrong");
    a_data_read : assert property (@(posedge i_clk)
        disable iff (i_sys_rst || o_core_rst) take && i_req.kind == EMB_DRD
        |-> ##5 !o_rd_n && o_wr_n && o_program_read_strobe_n && o_low_port_oe_n)
        else $error("read cycle wrong");
    a_reset_quiet : assert property (@(posedge i_clk)
        disable iff (i_sys_rst) o_core_rst && $past(o_core_rst, 2)
        |-> quiet && o_wr_n && o_rd_n && !o_req_ready) else $error("bus busy in reset");
    a_pin_hold : assert property (@(posedge i_clk)
        disable iff (i_sys_rst) $rose(o_core_rst) |-> pin_cnt_r >= 6'h18)
        else $error("reset pin accepted too short");
endmodule : emb_bus_chk
bind emb_bus_if emb_bus_chk u_chk (.i_clk, .i_sys_rst, .i_rst_pin, .i_external_fetch_select,
    .i_req_valid, .i_req, .o_req_ready, .o_rsp_valid, .o_core_rst, .o_low_port_out,
    .o_low_port_oe_n, .o_high_address_port, .o_ale, .o_program_read_strobe_n, .o_wr_n, .o_rd_n);

// [tb/emb_ext_mem.sv]
// Model of the outside address latch, program ROM and data RAM.
`timescale 1ns/1ps
module emb_ext_mem (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_port,     // Resolved low port level.
    input  wire logic [7:0] i_high,     // Upper address byte.
    input  wire logic       i_ale,
    input  wire logic       i_prog_rd_n,
    input  wire logic       i_rd_n,
    input  wire logic       i_wr_n,
    output logic            o_drv_en,   // High while a memory drives the port.
    output logic [7:0]      o_drv,
    output logic [7:0]      o_lat       // Latched low address byte.
);
    logic [7:0] ram [0:65535];          // Data space apart from code space.
    // The latch closes as the strobe falls and holds until the next one.
    always @(negedge i_ale) o_lat = i_port;
    always @(posedge i_clk) if (!i_wr_n) ram[{i_high, o_lat}] = i_port;
    // Only a selected memory drives; otherwise the pull-ups win.
    assign o_drv_en = !i_prog_rd_n || !i_rd_n;
    assign o_drv    = !i_prog_rd_n ? (i_high ^ o_lat ^ 8'h5A) : ram[{i_high, o_lat}];
endmodule : emb_ext_mem

// [tb/tb_external_memory_bus_interface.sv]
// Self-checking testbench of the external memory bus sequencer.
`timescale 1ns/1ps
module tb_external_memory_bus_interface;
    import emb_pkg::*;
    logic       clk, rst, pin, sel, valid, ready, rsp_v, core_rst, oe_n, ale, wr_n, rd_n;
    logic       drv_en, onc, prog_rd_n;
    emb_req_s   req;
    logic [7:0] rsp_d, port_out, high, port, drv, lat, d;
    int         fail_count = 0;
    int         compares   = 0;
    int         lo, oc;
    // Port 0 is open drain with pull-ups, so a released port reads all ones.
    assign port = !oe_n ? port_out : (drv_en ? drv : 8'hFF);
    emb_bus_if u_dut (.i_clk(clk), .i_ce(1'b1), .i_sys_rst(rst), .i_rst_pin(pin),
        .i_external_fetch_select(sel), .i_req_valid(valid), .i_req(req),
        .i_onchip_code(8'hC3), .i_low_port_in(port), .o_req_ready(ready), .o_rsp_valid(rsp_v),
        .o_rsp_data(rsp_d), .o_onchip_rd(onc), .o_core_rst(core_rst), .o_low_port_out(port_out),
        .o_low_port_oe_n(oe_n), .o_high_address_port(high), .o_ale(ale),
        .o_program_read_strobe_n(prog_rd_n), .o_wr_n(wr_n), .o_rd_n(rd_n));
    emb_ext_mem u_mem (.i_clk(clk), .i_port(port), .i_high(high), .i_ale(ale),
        .i_prog_rd_n(prog_rd_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
        .o_drv_en(drv_en), .o_drv(drv), .o_lat(lat));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    // One whole transfer; lo counts cycles with the program strobe low and
    // oc the cycles with the on-chip store read pulse high.
    task automatic access(input emb_kind_e k, input logic [15:0] a, input logic [7:0] w);
        int n;
        n = 0;
        @(negedge clk);
        req   = '{k, a, w};
        valid = 1'b1;
        while (!ready && n < 50) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        valid = 1'b0;
        lo    = 0;
        oc    = 0;
        while (!rsp_v && n < 100) begin
            lo += int'(!prog_rd_n);
            oc += int'(onc);
            @(negedge clk);
            n++;
        end
        d = rsp_d;
        chk(8'(n < 100), 8'h01);
    endtask : access
    // Code fetches and table reads, inside and outside the 16K store.
    task automatic t_code();
        logic [15:0] adr [5] = '{16'h3FFF, 16'h4000, 16'h0123, 16'hFFFF, 16'h0010};
        logic        sl  [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
        emb_kind_e   kd  [5] = '{EMB_FETCH, EMB_FETCH, EMB_FETCH, EMB_CTAB, EMB_CTAB};
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            sel = sl[i];
            repeat (4) @(negedge clk);
            access(kd[i], adr[i], 8'h00);
            if (sl[i] && adr[i] < 16'h4000) begin
                chk(d, 8'hC3);
                chk(8'(lo), 8'h00);
                chk(8'(oc), 8'h01);
            end else begin
                chk(8'(oc), 8'h00);
                chk(d, adr[i][15:8] ^ adr[i][7:0] ^ 8'h5A);
                chk(8'(lo > 0), 8'h01);
                chk(lat, adr[i][7:0]);
            end
        end
    endtask : t_code
    // Back-to-back data writes and reads share addresses with code.
    task automatic t_data();
        access(EMB_DWR, 16'h0123, 8'hA5);
        access(EMB_DWR, 16'hFF00, 8'h3C);
        access(EMB_DRD, 16'h0123, 8'h00);
        chk(d, 8'hA5);
        access(EMB_DRD, 16'hFF00, 8'h00);
        chk(d, 8'h3C);
        sel = 1'b0;
        repeat (4) @(negedge clk);
        access(EMB_FETCH, 16'h0123, 8'h00);
        chk(d, 8'h01 ^ 8'h23 ^ 8'h5A);
    endtask : t_data
    // A short pin pulse is ignored; a long one resets the device.
    task automatic t_pin();
        int n;
        n = 0;
        @(negedge clk);
        pin = 1'b1;
        repeat (12) @(negedge clk);
        pin = 1'b0;
        repeat (6) @(negedge clk);
        chk(8'(core_rst), 8'h00);
        pin = 1'b1;
        repeat (40) @(negedge clk);
        chk(8'(core_rst), 8'h01);
        chk(8'(ready), 8'h00);
        pin = 1'b0;
        while (core_rst && n < 20) begin
            @(negedge clk);
            n++;
        end
        access(EMB_DWR, 16'h00FF, 8'h77);
        access(EMB_DRD, 16'h00FF, 8'h00);
        chk(d, 8'h77);
    endtask : t_pin
    initial begin
        rst   = 1'b1;
        pin   = 1'b0;
        sel   = 1'b1;
        valid = 1'b0;
        req   = '0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        t_code();
        t_data();
        t_pin();
        finish_test();
    end
    // Watchdog: the tests need well under a thousand cycles.
    initial begin
        #50000;
        fail_count++;
        finish_test();
    end
endmodule : tb_external_memory_bus_interface
